// ===== design/ssw_pkg.sv
// Constants for the supply supervisor and watchdog
package ssw_pkg;
    // Clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // Times in ms
    localparam int HOLDOFF_SHORT_MS = 50;
    localparam int HOLDOFF_LONG_MS = 200;
    localparam int WD_LONG_MS = 1600;
    localparam int WD_SHORT_MS = 100;
    // Cycle counts derived from the 100 MHz clock
    localparam int HOLDOFF_SHORT_CYC =
        HOLDOFF_SHORT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int HOLDOFF_LONG_CYC =
        HOLDOFF_LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WD_LONG_CYC =
        WD_LONG_MS * 1000000 / CLK_PERIOD_NS;
    localparam int WD_SHORT_CYC =
        WD_SHORT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 28;
    // Reset values
    localparam logic RST_LEVEL_N = 1'h0;
    localparam logic [27:0] CNT_RST = 28'h0000000;
endpackage

// ===== design/ssw_supervisor.sv
// Supply supervisor with reset hold-off, gating and watchdog
// How it works
// [R1] Active-low reset held while supply is below threshold.
// [R2] Reset stays asserted for the hold-off after supply recovers.
// [R3] Active-high reset is always the inverse of the low one.
// [R4] Power-fail warning low when the sense comparator reads low.
// [R5] Chip enable passes while supply valid, forced high when low.
// [R6] Supply-low indicator follows the low-supply flag directly.
// [R7] Processor toggles the kick input within every timeout period.
// [R8] Static kick for a full timeout produces one hold-off reset pulse.
// [R9] Static kick repeats the reset pulse every timeout period.
// [R10] Expired output goes low on timeout until the next kick edge.
// [R11] A floating kick input disables the watchdog entirely.
// [R12] Without selection inputs the timeout is the long period.
// [R13] Backup-active indicator high while rail is fed from battery.
// [R14] Supply below battery forces the power-fail warning low.
// [R15] Expired output forced high while the supply is low.
// [R16] Watchdog timer restarts at the end of every reset pulse.
// [R17] Supply below battery also forces chip enable high.
// [R18] Times are counted cycles; comparator flags are synchronised.
// [R19] Either edge of the synchronised kick input is a service event.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor
#(
    parameter int HOLDOFF_SHORT = ssw_pkg::HOLDOFF_SHORT_CYC,
    parameter int HOLDOFF_LONG = ssw_pkg::HOLDOFF_LONG_CYC,
    parameter int WD_LONG = ssw_pkg::WD_LONG_CYC,
    parameter int WD_SHORT = ssw_pkg::WD_SHORT_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_low_in,
    input wire logic supply_below_backup_in,
    input wire logic power_fail_sense_in,
    input wire logic chip_enable_in_n,
    input wire logic watchdog_kick_in,
    input wire logic watchdog_kick_float_in,
    input wire logic long_holdoff_sel,
    input wire logic timebase_source_sel,
    input wire logic timebase_select_in,
    output logic reset_n,
    output logic reset_out,
    output logic power_fail_warn_n,
    output logic chip_enable_out_n,
    output logic supply_low_n,
    output logic watchdog_expired_n,
    output logic backup_active
);
    import ssw_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Two stages each; bit order: low, below_backup, pf, kick, float
    // Reset value reads as supply low, so outputs come up in the safe
    // state until the first real comparator sample arrives
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic kick_prev_q;
    wire logic [4:0] raw_in;
    assign raw_in = {watchdog_kick_float_in, watchdog_kick_in,
        power_fail_sense_in, supply_below_backup_in, supply_low_in};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_q <= 5'h01;
            sync2_q <= 5'h01;
            kick_prev_q <= 1'h0;
        end
        else
        begin
            sync1_q <= raw_in; // [R18]
            sync2_q <= sync1_q;
            kick_prev_q <= sync2_q[3];
        end
    end

    wire logic low_s;
    wire logic below_bat_s;
    wire logic pf_s;
    wire logic kick_s;
    wire logic float_s;
    wire logic kick_edge;
    assign low_s = sync2_q[0];
    assign below_bat_s = sync2_q[1];
    assign pf_s = sync2_q[2];
    assign kick_s = sync2_q[3];
    assign float_s = sync2_q[4];
    assign kick_edge = (kick_s ^ kick_prev_q) && !float_s; // [R19]

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    // LOW waits for the supply, HOLD times the reset pulse, RUN counts
    // the watchdog; a low supply overrides every state at once
    // Limitation: the hold-off restarts on any supply glitch
    typedef enum logic [1:0] {SSW_RUN, SSW_LOW, SSW_HOLD} ssw_state_e;
    ssw_state_e state_q;
    ssw_state_e state_d;
    logic [CNT_W-1:0] hold_q;
    logic [CNT_W-1:0] hold_d;
    logic [CNT_W-1:0] wd_q;
    logic [CNT_W-1:0] wd_d;
    logic expired_q;
    logic expired_d;
    logic after_reset_q;
    logic after_reset_d;
    logic rst_n_q;

    wire logic [CNT_W-1:0] hold_len;
    wire logic [CNT_W-1:0] wd_len;
    wire logic short_wd;
    wire logic wd_timeout;
    wire logic hold_done;
    // Short period only with internal timebase and select pin low; the
    // period right after any reset is always the long one
    assign short_wd = timebase_source_sel && !timebase_select_in
        && !after_reset_q;
    assign hold_len = long_holdoff_sel ? CNT_W'(HOLDOFF_LONG)
        : CNT_W'(HOLDOFF_SHORT); // [R2]
    assign wd_len = short_wd ? CNT_W'(WD_SHORT) : CNT_W'(WD_LONG); // [R12]
    assign wd_timeout = !float_s && (wd_q >= wd_len - 1'b1); // [R11]
    assign hold_done = hold_q >= hold_len - 1'b1;

    always_comb
    begin
        state_d = state_q;
        hold_d = hold_q;
        wd_d = wd_q;
        expired_d = expired_q;
        after_reset_d = after_reset_q;
        case (state_q)
            SSW_RUN:
            begin
                if (kick_edge)
                begin
                    wd_d = CNT_RST; // [R19]
                    expired_d = 1'b0; // [R10]
                    after_reset_d = 1'b0;
                end
                else if (float_s)
                    wd_d = CNT_RST; // [R11]
                else if (wd_timeout)
                begin
                    state_d = SSW_HOLD; // [R8] [R9]
                    hold_d = CNT_RST;
                    wd_d = CNT_RST;
                    expired_d = 1'b1; // [R10]
                end
                else
                    wd_d = wd_q + 1'b1;
            end
            SSW_LOW:
            begin
                hold_d = CNT_RST;
                expired_d = 1'b0; // [R15]
                if (!low_s)
                    state_d = SSW_HOLD; // [R2]
            end
            SSW_HOLD:
            begin
                if (kick_edge)
                    expired_d = 1'b0; // [R10]
                if (hold_done)
                begin
                    state_d = SSW_RUN;
                    wd_d = CNT_RST; // [R16]
                    after_reset_d = 1'b1;
                end
                else
                    hold_d = hold_q + 1'b1;
            end
            default:
                state_d = SSW_LOW;
        endcase
        if (low_s)
        begin
            state_d = SSW_LOW; // [R1]
            expired_d = 1'b0; // [R15]
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= SSW_LOW;
            hold_q <= CNT_RST;
            wd_q <= CNT_RST;
            expired_q <= 1'b0;
            after_reset_q <= 1'b1;
            rst_n_q <= RST_LEVEL_N;
        end
        else
        begin
            state_q <= state_d;
            hold_q <= hold_d;
            wd_q <= wd_d;
            expired_q <= expired_d;
            after_reset_q <= after_reset_d;
            rst_n_q <= (state_d == SSW_RUN); // [R1] [R2]
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Gating paths stay combinational so that write protection does not
    // wait for a clock edge after the comparator flag arrives
    // Reset and expired outputs are registered so that they cannot
    // glitch while the sequencer changes state
    // Trade-off: gating still carries the two-cycle synchroniser delay
    assign reset_n = rst_n_q;
    assign reset_out = !rst_n_q; // [R3]
    assign power_fail_warn_n = pf_s && !below_bat_s; // [R4] [R14]
    assign chip_enable_out_n = chip_enable_in_n || low_s
        || below_bat_s; // [R5] [R17]
    assign supply_low_n = !low_s; // [R6]
    assign watchdog_expired_n = !expired_q; // [R10] [R15]
    assign backup_active = below_bat_s; // [R13]

    // ************************************************************
    // Checks
    // ************************************************************
    // All checks sample on the block clock and rest while in reset
    // They watch the synchronised flags, since raw pins are two cycles
    // ahead of anything the logic can act on
    low_holds_reset_a: assert property ( // [R1]
        @(posedge clk) disable iff (!resetn)
        low_s |=> !reset_n)
        else $error("reset released while supply low");

    hold_release_a: assert property ( // [R2]
        @(posedge clk) disable iff (!resetn)
        (state_q == SSW_HOLD && !hold_done && !low_s) |=> !reset_n)
        else $error("reset released before hold-off");

    inverse_reset_a: assert property ( // [R3]
        @(posedge clk) disable iff (!resetn)
        reset_out == !reset_n)
        else $error("reset outputs not inverse");

    pf_warn_a: assert property ( // [R4]
        @(posedge clk) disable iff (!resetn)
        (!pf_s || below_bat_s) |-> !power_fail_warn_n)
        else $error("power fail warning missing");

    ce_gate_a: assert property ( // [R5]
        @(posedge clk) disable iff (!resetn)
        (low_s || below_bat_s) |-> chip_enable_out_n)
        else $error("chip enable not blocked");

    ce_pass_a: assert property ( // [R5]
        @(posedge clk) disable iff (!resetn)
        (!low_s && !below_bat_s) |-> chip_enable_out_n == chip_enable_in_n)
        else $error("chip enable not passed");

    low_indicator_a: assert property ( // [R6]
        @(posedge clk) disable iff (!resetn)
        supply_low_n == !low_s)
        else $error("supply low indicator wrong");

    timeout_pulse_a: assert property ( // [R8]
        @(posedge clk) disable iff (!resetn)
        (state_q == SSW_RUN && wd_timeout && !kick_edge && !low_s)
        |=> !reset_n && !watchdog_expired_n)
        else $error("timeout gave no reset");

    expired_hold_a: assert property ( // [R10]
        @(posedge clk) disable iff (!resetn)
        (!watchdog_expired_n && !kick_edge && !low_s)
        |=> !watchdog_expired_n)
        else $error("expired output released early");

    float_off_a: assert property ( // [R11]
        @(posedge clk) disable iff (!resetn)
        (float_s && state_q == SSW_RUN && !low_s) |=> state_q == SSW_RUN)
        else $error("watchdog active while floating");

    batt_ind_a: assert property ( // [R13]
        @(posedge clk) disable iff (!resetn)
        backup_active == below_bat_s)
        else $error("backup indicator wrong");

    expired_low_a: assert property ( // [R15]
        @(posedge clk) disable iff (!resetn)
        low_s |=> watchdog_expired_n)
        else $error("expired not forced high");

    restart_wd_a: assert property ( // [R16]
        @(posedge clk) disable iff (!resetn)
        (state_q == SSW_HOLD && hold_done && !low_s) |=> wd_q == CNT_RST)
        else $error("watchdog not restarted");

    kick_clear_a: assert property ( // [R10]
        @(posedge clk) disable iff (!resetn)
        (kick_edge && !low_s) |=> watchdog_expired_n)
        else $error("kick did not clear expired");

    kick_restart_a: assert property ( // [R19]
        @(posedge clk) disable iff (!resetn)
        (state_q == SSW_RUN && kick_edge && !low_s) |=> wd_q == CNT_RST)
        else $error("kick did not restart watchdog");
endmodule
`default_nettype wire

// ===== tb/ssw_cpu_model.sv
// Processor model that services the watchdog kick line
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model
#(
    parameter int KICK_GAP = 10
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic kick_en,
    output var logic kick
);
    int gap_q = 0;
    logic kick_q = 1'b0;
    assign kick = kick_q;
    // A program held in reset cannot kick, so the gap restarts there
    always @(posedge clk)
    begin
        if (!reset_n || !kick_en)
            gap_q <= 0;
        else if (gap_q == KICK_GAP - 1)
        begin
            gap_q <= 0;
            kick_q <= ~kick_q;
        end
        else
            gap_q <= gap_q + 1;
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the supply supervisor and watchdog
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %s exp %0h seen %0h", nm, e, g); end end
module tb;
    localparam int HS = 20;
    localparam int HL = 40;
    localparam int WL = 100;
    localparam int WS = 50;
    logic clk = 1'b0, resetn = 1'b0, sl = 1'b0, bb = 1'b0, ps = 1'b1;
    logic ce_n = 1'b1, kick, flt = 1'b0, lsel = 1'b0, tsel = 1'b1, src = 1'b1;
    logic ken = 1'b1, reset_n, reset_out, pfw_n, ceo_n, low_n, exp_n, bat;
    int miscompares = 0, checks_done = 0, n, i, seed = 32'h11c1d7b5;
    logic [3:0] r, e;
    ssw_supervisor #(.HOLDOFF_SHORT(HS), .HOLDOFF_LONG(HL), .WD_LONG(WL),
        .WD_SHORT(WS)) u_ssw_supervisor (.clk(clk), .resetn(resetn),
        .supply_low_in(sl), .supply_below_backup_in(bb),
        .power_fail_sense_in(ps), .chip_enable_in_n(ce_n),
        .watchdog_kick_in(kick), .watchdog_kick_float_in(flt),
        .long_holdoff_sel(lsel), .timebase_source_sel(src),
        .timebase_select_in(tsel), .reset_n(reset_n), .reset_out(reset_out),
        .power_fail_warn_n(pfw_n), .chip_enable_out_n(ceo_n),
        .supply_low_n(low_n), .watchdog_expired_n(exp_n),
        .backup_active(bat));
    ssw_cpu_model u_ssw_cpu_model (.clk(clk), .reset_n(reset_n),
        .kick_en(ken), .kick(kick));
    always #5 clk = ~clk;
    always @(negedge clk)
        if (resetn) `CHK("reset_out", ~reset_n, reset_out)
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Gating outputs as the rules ask: {ce_out, pf_warn, low_ind, backup_active}
    function automatic logic [3:0] exp_gate(input logic [3:0] v);
        exp_gate = {v[3] | v[0] | v[1], v[2] & ~v[1], ~v[0], v[1]};
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic in_set(input logic a, b, c, d);
        @(posedge clk);
        sl <= a;
        bb <= b;
        ps <= c;
        ce_n <= d;
    endtask
    // Counts cycles until the reset output reaches a level
    task automatic wait_rst(input logic v, output int cnt);
        cnt = 0;
        while (reset_n !== v && cnt < 1000)
        begin
            tick(1);
            cnt++;
        end
    endtask
    initial
    begin
        #300us;
        miscompares++;
        finish_test();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wait_rst(1'b1, n);
        `CHK("hold", 1'b1, n >= HS && n <= HS + 8)
        for (i = 0; i < 24; i++)
        begin
            r = $random(seed);
            if (i < 2)
                r = {4{i[0]}};
            in_set(r[0], r[1], r[2], r[3]);
            tick(4);
            e = exp_gate(r);
            `CHK("ce_out", e[3], ceo_n)
            `CHK("pf_warn", e[2], pfw_n)
            `CHK("low_ind", e[1], low_n)
            `CHK("backup_active", e[0], bat)
            if (r[0])
                `CHK("rst_low", 1'b0, reset_n)
        end
        in_set(1'b0, 1'b0, 1'b1, 1'b1);
        wait_rst(1'b1, n);
        tick(300);
        `CHK("kicked", 1'b1, exp_n & reset_n)
        @(posedge clk);
        flt <= 1'b1;
        ken <= 1'b0;
        tick(350);
        `CHK("float", 1'b1, exp_n & reset_n)
        @(posedge clk);
        flt <= 1'b0;
        wait_rst(1'b0, n);
        `CHK("timeout", 1'b1, n <= WL + 8)
        tick(1);
        `CHK("expired", 1'b0, exp_n)
        wait_rst(1'b1, n);
        `CHK("wd_pulse", 1'b1, n >= HS - 2 && n <= HS + 3)
        wait_rst(1'b0, n);
        `CHK("repeat", 1'b1, n >= WL - 3 && n <= WL + 5)
        wait_rst(1'b1, n);
        in_set(1'b1, 1'b0, 1'b1, 1'b1);
        lsel <= 1'b1;
        tick(4);
        `CHK("exp_clr", 1'b1, exp_n)
        in_set(1'b0, 1'b0, 1'b1, 1'b1);
        wait_rst(1'b1, n);
        `CHK("long_hold", 1'b1, n >= HL && n <= HL + 8)
        wait_rst(1'b0, n);
        `CHK("restart", 1'b1, n >= WL - 3 && n <= WL + 5)
        @(posedge clk);
        ken <= 1'b1;
        tick(70);
        `CHK("kick_clr", 1'b1, exp_n)
        @(posedge clk);
        tsel <= 1'b0;
        tick(200);
        @(posedge clk);
        ken <= 1'b0;
        wait_rst(1'b0, n);
        `CHK("short_to", 1'b1, n >= WS - 12 && n <= WS + 8)
        wait_rst(1'b1, n);
        @(posedge clk);
        src <= 1'b0;
        ken <= 1'b1;
        tick(150);
        @(posedge clk);
        ken <= 1'b0;
        wait_rst(1'b0, n);
        `CHK("ext_src", 1'b1, n >= WL - 12 && n <= WL + 8)
        @(posedge clk);
        resetn <= 1'b0;
        tick(3);
        `CHK("in_reset", 5'h06, {reset_n, low_n, ceo_n, exp_n, pfw_n})
        @(posedge clk);
        resetn <= 1'b1;
        wait_rst(1'b1, n);
        `CHK("rst_again", 1'b1, n >= HL && n <= HL + 8)
        finish_test();
    end
endmodule
`default_nettype wire
